// ==== rtl/owps_pkg.sv ====
package owps_pkg;

   // ==========================================================
   // widths
   localparam int unsigned PW = 16;  // pulse and period counters
   localparam int unsigned TW = 24;  // timeout and mode counters
   localparam int unsigned DW = 16;  // data word
   localparam int unsigned AW = 7;   // command address

   // ==========================================================
   // timing
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned IDLE_TO_US = 250;
   localparam int unsigned TKO_US = 2;      // inside the 1 to 5 us band
   localparam int unsigned ON_DLY_US = 2000;
   localparam int unsigned SLOT_US = 20000;
   localparam logic [TW-1:0] IDLE_TO_CYC =
      TW'((IDLE_TO_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [PW-1:0] TKO_CYC =
      PW'((TKO_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] ON_DLY_CYC =
      TW'((ON_DLY_US * 1000 + CLK_NS - 1) / CLK_NS);
   localparam logic [TW-1:0] SLOT_CYC =
      TW'((SLOT_US * 1000 + CLK_NS - 1) / CLK_NS);

   // ==========================================================
   // frame layout
   localparam logic [4:0] CMD_LAST = 5'h07;
   localparam logic [4:0] DATA_LAST = 5'h0f;
   localparam logic [4:0] TX_HANDOVER = 5'h10;
   localparam int unsigned RW_BIT = 0;
   localparam logic RW_READ = 1'b1;

   // ==========================================================
   // modes and states
   typedef enum logic [1:0] {
      MODE_SLOT,
      MODE_NORMAL,
      MODE_CMD
   } owps_mode_e;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_WR,
      ST_RD_HO,
      ST_RD_TKO,
      ST_RD_TX,
      ST_RD_WAIT,
      ST_SKIP
   } owps_state_e;

   // ==========================================================
   // helpers
   function automatic logic [PW-1:0] owps_sat_inc(input logic [PW-1:0] v);
      owps_sat_inc = (v == {PW{1'b1}}) ? v : v + 1'b1;
   endfunction

   // high time of a sent bit: three quarters for one, a quarter for zero
   function automatic logic [PW-1:0] owps_hi_width(input logic [PW-1:0] p,
                                                   input logic b);
      owps_hi_width = b ? (p >> 1) + (p >> 2) : (p >> 2);
   endfunction

endpackage

// ==== rtl/owps_bit_rx.sv ====
`timescale 1ns/10ps
module owps_bit_rx (
   input wire logic i_clk_sys,                 // system clock
   input wire logic i_rst_b,                   // sync reset, low
   input wire logic i_link,                    // pin level
   input wire logic i_clear,                   // drop bit framing
   output logic o_rise,                        // rising edge pulse
   output logic o_fall,                        // falling edge pulse
   output logic o_bit_valid,                   // one decoded bit
   output logic o_bit,                         // decoded bit value
   output logic [owps_pkg::PW-1:0] o_period    // last bit period
);
   import owps_pkg::*;

   logic link_q;
   logic armed;
   logic [PW-1:0] per_cnt;
   logic [PW-1:0] hi_cnt;

   assign o_rise = i_link & ~link_q;
   assign o_fall = ~i_link & link_q;

   // resets high so a line already high is not seen as an edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) link_q <= 1'b1;
      else link_q <= i_link;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || i_clear) armed <= 1'b0;
      else if (o_rise) armed <= 1'b1;
   end

   // ==========================================================
   // period from rise to rise, high time inside it
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         per_cnt <= '0;
         hi_cnt <= '0;
      end else if (o_rise) begin
         per_cnt <= 16'h0001;
         hi_cnt <= 16'h0001;
      end else begin
         per_cnt <= owps_sat_inc(per_cnt);
         if (i_link) hi_cnt <= owps_sat_inc(hi_cnt);
      end
   end

   // a bit closes at the rise that opens the next one
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_bit_valid <= 1'b0;
         o_bit <= 1'b0;
         o_period <= '0;
      end else begin
         o_bit_valid <= o_rise & armed & ~i_clear;
         if (o_rise) begin
            o_bit <= {hi_cnt, 1'b0} > {1'b0, per_cnt};
            o_period <= per_cnt;
         end
      end
   end

endmodule // owps_bit_rx

// ==== rtl/owps_link_slave.sv ====
`timescale 1ns/10ps
// Functional notes
// - device only answers, master runs every transfer
// - command byte: seven address bits, low bit read
// - every field goes most significant bit first
// - long high pulse one, short high zero
// - no rise for idle timeout resets receiver
// - timed out write is discarded
// - after handover fall, drive low, send bytes
// - device handover zero, release at three quarters
// - missing takeover ends by stop or timeout
// - missed entry slot ignores link afterwards
// - command mode frees pin; output driven before
// - only power-on reset leaves command mode
// - diagnostic mode still accepts access key write
// - normal operation starts after power-on delay
// - link reset within idle timeout, 250 us
// - takeover low held between 1 and 5 us
module owps_link_slave #(
   parameter logic [owps_pkg::TW-1:0] IDLE_CYC = owps_pkg::IDLE_TO_CYC,
   parameter logic [owps_pkg::TW-1:0] ON_CYC = owps_pkg::ON_DLY_CYC,
   parameter logic [owps_pkg::TW-1:0] SLOT_CYC = owps_pkg::SLOT_CYC,
   parameter logic [owps_pkg::AW-1:0] ENTRY_ADDR = 7'h2a,  // arbitrary
   parameter logic [owps_pkg::DW-1:0] ENTRY_KEY = 16'h5a5a // arbitrary
) (
   input wire logic i_clk_sys,                   // system clock
   input wire logic i_rst_b,                     // power-on reset, low
   input wire logic i_link,                      // pin level in
   output logic o_link,                          // pin level out
   output logic o_link_oe,                       // pin driver on
   input wire logic i_normal_out,                // normal output level
   input wire logic i_diag_mode,                 // device in diagnostic
   output logic o_cmd_mode,                      // command mode active
   output logic o_normal_run,                    // normal operation on
   output logic o_wr_stb,                        // write pulse
   output logic [owps_pkg::AW-1:0] o_wr_addr,    // write address
   output logic [owps_pkg::DW-1:0] o_wr_data,    // write word
   output logic o_rd_req,                        // read request pulse
   output logic [owps_pkg::AW-1:0] o_rd_addr,    // read address
   input wire logic [owps_pkg::DW-1:0] i_rd_data // read word
);
   import owps_pkg::*;

   owps_state_e state;
   owps_mode_e mode;
   logic rx_rise, rx_fall, rx_valid, rx_bit, rx_clear;
   logic [PW-1:0] rx_period;
   logic [7:0] cmd_sh;
   logic [DW-1:0] data_sh;
   logic [4:0] bcnt;
   logic [TW-1:0] tmo_cnt;
   logic [TW-1:0] up_cnt;
   logic [PW-1:0] period;
   logic [PW-1:0] phase;
   logic [4:0] tx_idx;
   logic [DW-1:0] tx_sh;
   logic link_en, tmo_hit, driving;
   logic cmd_done, wr_done, tko_end, bit_end, ho_release;
   logic entry_hit, tx_level;
   logic [DW-1:0] wr_word;
   logic [PW-1:0] hw;

   owps_bit_rx u_rx (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_link(i_link),
      .i_clear(rx_clear),
      .o_rise(rx_rise),
      .o_fall(rx_fall),
      .o_bit_valid(rx_valid),
      .o_bit(rx_bit),
      .o_period(rx_period)
   );

   // ==========================================================
   // decode of frame events
   assign driving = (state == ST_RD_TKO) || (state == ST_RD_TX);
   assign link_en = (mode == MODE_SLOT) || (mode == MODE_CMD) ||
                    ((mode == MODE_NORMAL) && i_diag_mode);
   assign tmo_hit = (state != ST_IDLE) && !rx_rise &&
                    (tmo_cnt >= IDLE_CYC - 1'b1);
   assign rx_clear = driving || tmo_hit ||
                     ((state == ST_IDLE) && !rx_rise);
   assign cmd_done = (state == ST_CMD) && rx_valid && (bcnt == CMD_LAST);
   assign wr_done = (state == ST_WR) && rx_valid && (bcnt == DATA_LAST);
   assign wr_word = {data_sh[DW-2:0], rx_bit};
   assign entry_hit = wr_done && (cmd_sh[7:1] == ENTRY_ADDR) &&
                      (wr_word == ENTRY_KEY) && (mode != MODE_CMD);
   assign tko_end = (state == ST_RD_TKO) && (phase == TKO_CYC - 1'b1);
   assign bit_end = (state == ST_RD_TX) && (phase == period - 1'b1);
   assign ho_release = (state == ST_RD_TX) && (tx_idx == TX_HANDOVER) &&
                       (phase >= owps_hi_width(period, 1'b1));
   assign hw = owps_hi_width(period,
                             (tx_idx == TX_HANDOVER) ? 1'b0 : tx_sh[DW-1]);
   assign tx_level = (state == ST_RD_TX) && (phase < hw);

   // ==========================================================
   // mode: entry slot, normal run, command mode
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) up_cnt <= '0;
      else if (up_cnt != {TW{1'b1}}) up_cnt <= up_cnt + 1'b1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) mode <= MODE_SLOT;
      else case (mode)
         MODE_SLOT: begin
            if (entry_hit) mode <= MODE_CMD;
            else if (up_cnt >= SLOT_CYC) mode <= MODE_NORMAL;
         end
         MODE_NORMAL: begin
            if (entry_hit && i_diag_mode) mode <= MODE_CMD;
         end
         MODE_CMD: mode <= MODE_CMD;
         default: mode <= MODE_SLOT;
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_cmd_mode <= 1'b0;
         o_normal_run <= 1'b0;
      end else begin
         o_cmd_mode <= (mode == MODE_CMD);
         o_normal_run <= (mode != MODE_CMD) &&
                         (up_cnt >= ON_CYC);
      end
   end

   // ==========================================================
   // idle timeout, restarted by every rise
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || rx_rise || driving || state == ST_IDLE)
         tmo_cnt <= '0;
      else if (tmo_cnt != {TW{1'b1}}) tmo_cnt <= tmo_cnt + 1'b1;
   end

   // ==========================================================
   // transfer sequencing
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || !link_en || tmo_hit) state <= ST_IDLE;
      else case (state)
         ST_IDLE: if (rx_rise) state <= ST_CMD;
         ST_CMD: begin
            if (cmd_done) begin
               if (rx_bit != RW_READ) state <= ST_WR;
               else if (mode == MODE_CMD) state <= ST_RD_HO;
               else state <= ST_SKIP;
            end
         end
         ST_WR: if (wr_done) state <= ST_IDLE;
         ST_RD_HO: if (rx_fall) state <= ST_RD_TKO;
         ST_RD_TKO: if (tko_end) state <= ST_RD_TX;
         ST_RD_TX: if (ho_release) state <= ST_RD_WAIT;
         ST_RD_WAIT: if (rx_rise) state <= ST_IDLE;
         ST_SKIP: state <= ST_SKIP;
         default: state <= ST_IDLE;
      endcase
   end

   // ==========================================================
   // receive shift registers
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b || state == ST_IDLE) begin
         cmd_sh <= '0;
         data_sh <= '0;
         bcnt <= '0;
      end else if (rx_valid) begin
         if (state == ST_CMD) begin
            cmd_sh <= {cmd_sh[6:0], rx_bit};
            bcnt <= cmd_done ? 5'h00 : bcnt + 1'b1;
         end else if (state == ST_WR) begin
            data_sh <= wr_word;
            bcnt <= bcnt + 1'b1;
         end
      end
   end

   // ==========================================================
   // read answer timing; period recovered from the last command bit
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         period <= '0;
         phase <= '0;
         tx_idx <= '0;
         tx_sh <= '0;
      end else begin
         if (cmd_done) period <= rx_period;
         if (state == ST_RD_HO && rx_fall) begin
            phase <= '0;
            tx_sh <= i_rd_data;
         end else if (tko_end) begin
            phase <= '0;
            tx_idx <= '0;
         end else if (bit_end) begin
            phase <= '0;
            tx_idx <= tx_idx + 1'b1;
            tx_sh <= {tx_sh[DW-2:0], 1'b0};
         end else if (driving) begin
            phase <= phase + 1'b1;
         end
      end
   end

   // ==========================================================
   // user side strobes and pin drive
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_wr_stb <= 1'b0;
         o_wr_addr <= '0;
         o_wr_data <= '0;
         o_rd_req <= 1'b0;
         o_rd_addr <= '0;
      end else begin
         // only a full frame closed by stop reaches memory
         o_wr_stb <= wr_done && (mode == MODE_CMD) && !tmo_hit;
         if (wr_done) begin
            o_wr_addr <= cmd_sh[7:1];
            o_wr_data <= wr_word;
         end
         o_rd_req <= cmd_done && (rx_bit == RW_READ) &&
                     (mode == MODE_CMD);
         if (cmd_done) o_rd_addr <= cmd_sh[6:0];
      end
   end

   // master overdrives the live output until command mode
   // idles high in reset so its release makes no false start
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_link <= 1'b1;
         o_link_oe <= 1'b1;
      end else if (mode != MODE_CMD) begin
         o_link <= i_normal_out;
         o_link_oe <= 1'b1;
      end else begin
         o_link <= tx_level;
         o_link_oe <= driving;
      end
   end

   // ==========================================================
   // checks
   localparam int A_TKO = TKO_CYC;

   a_tko_hold_time: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      (state == ST_RD_HO && rx_fall && link_en && !tmo_hit) |=>
      ##A_TKO (state == ST_RD_TX) && $past(state == ST_RD_TKO))
      else $error("takeover low time wrong");

   a_timeout_idle: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      tmo_hit |=> (state == ST_IDLE) && !o_wr_stb)
      else $error("timeout did not reset receiver");

   a_wr_discard: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      o_wr_stb |-> $past(state == ST_WR) && $past(bcnt == DATA_LAST))
      else $error("write issued without full frame");

   a_cmd_sticky: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      (mode == MODE_CMD) |=> (mode == MODE_CMD))
      else $error("command mode left without reset");

   a_no_link_normal: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      (mode == MODE_NORMAL && !i_diag_mode) |=> (state == ST_IDLE))
      else $error("link active in normal operation");

   a_entry_output_on: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      $past(mode != MODE_CMD) |-> o_link_oe && !o_cmd_mode)
      else $error("output off before command mode");

   a_cmd_pin_release: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      ($past(mode == MODE_CMD) && !$past(driving)) |-> !o_link_oe)
      else $error("pin driven outside read answer");

   a_rd_req_read: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      o_rd_req |-> $past(rx_bit == RW_READ) && (state == ST_RD_HO))
      else $error("read request without read flag");

   a_handover_release: assert property (@(posedge i_clk_sys)
      disable iff (!i_rst_b)
      (ho_release && link_en && !tmo_hit) |=>
      (state == ST_RD_WAIT) ##1 !o_link_oe)
      else $error("handover release wrong");

endmodule // owps_link_slave

// ==== test/owps_master_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// programming master on the far side of the pin
module owps_master_model #(
   parameter int P = 40
) (
   input wire logic i_clk_sys, // system clock
   output logic o_oe,          // master drives pin
   output logic o_lvl          // master pin level
);
   initial begin
      o_oe = 1'b0;
      o_lvl = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   // the rise opens the bit, the high width carries it
   task automatic send_bit(input logic b);
      o_lvl <= 1'b1;
      tick(b ? 3 * P / 4 : P / 4);
      o_lvl <= 1'b0;
      tick(b ? P / 4 : 3 * P / 4);
   endtask

   // low first so the opening rise is a start
   task automatic frame(input int n, input logic [23:0] v,
                        input logic stop);
      o_oe <= 1'b1;
      o_lvl <= 1'b0;
      tick(P / 2);
      for (int i = n - 1; i >= 0; i--) send_bit(v[i]);
      if (stop) begin
         o_lvl <= 1'b1;
         tick(4);
         o_oe <= 1'b0;
      end
   endtask

   // handover zero, released at three quarters
   task automatic handover;
      o_lvl <= 1'b1;
      tick(P / 4);
      o_lvl <= 1'b0;
      tick(P / 2);
      o_oe <= 1'b0;
   endtask

   // master holds the line low after the device's handover
   task automatic take_low;
      o_oe <= 1'b1;
      o_lvl <= 1'b0;
   endtask

   // rise after that low closes the read
   task automatic close_read;
      o_lvl <= 1'b1;
      tick(4);
      o_oe <= 1'b0;
   endtask
endmodule // owps_master_model

// ==== test/one_wire_programming_slave_test.sv ====
`timescale 1ns/10ps
module one_wire_programming_slave_test;
   import owps_pkg::*;
   localparam int P = 40;
   // scaled: the block keeps no programming timer of its own
   localparam int PROG_GAP = 200;
   localparam logic [AW-1:0] EA = 7'h2a;
   localparam logic [DW-1:0] EK = 16'h5a5a;
   logic clk, rst_b, n_out, diag, dut_lvl, dut_oe, cmd, nrun;
   logic wr_stb, rd_req, m_oe, m_lvl;
   logic [AW-1:0] wr_addr, rd_addr, wr_a, rd_a;
   logic [DW-1:0] rd_data, wr_data, wr_d;
   int bad_count, n_checks, wr_cnt, rd_cnt;
   // master wins while overdriving; released line has a pull-up
   wire link = m_oe ? m_lvl : (dut_oe ? dut_lvl : 1'b1);

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   owps_link_slave #(.IDLE_CYC(24'd400), .ON_CYC(24'd50),
      .SLOT_CYC(24'd5000), .ENTRY_ADDR(EA), .ENTRY_KEY(EK)) dut_u (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_link(link), .o_link(dut_lvl),
      .o_link_oe(dut_oe), .i_normal_out(n_out), .i_diag_mode(diag),
      .o_cmd_mode(cmd), .o_normal_run(nrun), .o_wr_stb(wr_stb),
      .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_req(rd_req),
      .o_rd_addr(rd_addr), .i_rd_data(rd_data));

   owps_master_model #(.P(P)) mdl_u (.i_clk_sys(clk), .o_oe(m_oe),
      .o_lvl(m_lvl));

   always @(posedge clk) begin
      if (wr_stb === 1'b1) begin
         wr_cnt++;
         wr_a = wr_addr;
         wr_d = wr_data;
      end
      if (rd_req === 1'b1) begin
         rd_cnt++;
         rd_a = rd_addr;
      end
   end

   // ==========================================================
   // helpers
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk_bit(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_word(input logic [16:0] g, input logic [16:0] e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // counts cycles until the wire shows v; a hang ends the run
   task automatic wait_lvl(input logic v, output int n);
      n = 0;
      while (link !== v) begin
         @(posedge clk);
         n++;
         if (n > 2000) begin
            bad_count++;
            $display("MISMATCH t=%0t wire stuck at %h", $time, link);
            give_verdict();
         end
      end
   endtask

   task automatic do_reset;
      rst_b <= 1'b0;
      tick(16);
      rst_b <= 1'b1;
      tick(1);
   endtask

   task automatic wr_frame(input logic [6:0] a, input logic [15:0] d);
      mdl_u.frame(24, {a, 1'b0, d}, 1'b1);
      tick(4);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      do_reset();
      chk_bit(dut_oe, 1'b1);
      chk_bit(cmd, 1'b0);
      chk_bit(nrun, 1'b0);
      tick(100);
      chk_bit(nrun, 1'b1);
      chk_bit(dut_lvl, 1'b1);
      n_out <= 1'b0;
      tick(2);
      chk_bit(dut_lvl, 1'b0);
      n_out <= 1'b1;
      tick(450); // line high beyond the idle timeout
      $display("t_reset done");
   endtask

   task automatic t_entry;
      mdl_u.frame(8, {16'h0, 7'h33, 1'b1}, 1'b1);
      tick(450); // skipped read ends by timeout
      chk_word(17'(rd_cnt), 17'h0);
      wr_frame(7'h11, 16'h1234);
      chk_bit(cmd, 1'b0);
      wr_frame(EA, EK);
      chk_bit(cmd, 1'b1);
      chk_bit(dut_oe, 1'b0);
      chk_word(17'(wr_cnt), 17'h0);
      $display("t_entry done");
   endtask

   // spaced by the programming gap, with all-zero and boundary values
   task automatic t_write;
      logic [6:0] a[2] = '{7'h55, 7'h00};
      logic [15:0] d[2] = '{16'ha3c1, 16'h8001};
      for (int i = 0; i < 2; i++) begin
         // the closing word plays the checksum rewrite
         mdl_u.frame(24, {a[i], 1'b0, d[i]}, 1'b1);
         chk_word(17'(wr_cnt), 17'(i + 1));
         chk_word(17'(wr_a), 17'(a[i]));
         chk_word(17'(wr_d), 17'(d[i]));
         tick(PROG_GAP);
      end
      tick(4);
      $display("t_write done");
   endtask

   task automatic t_timeout;
      mdl_u.frame(12, {12'h0, 7'h0f, 1'b0, 4'hf}, 1'b0);
      tick(500);
      chk_word(17'(wr_cnt), 17'h2);
      wr_frame(7'h0f, 16'h1234);
      chk_word(17'(wr_cnt), 17'h3);
      chk_word(17'(wr_d), 17'h1234);
      $display("t_timeout done");
   endtask

   // master takeover, or none so the pull-up forms the stop
   task automatic t_read(input logic tko, input logic [6:0] a,
                         input logic [15:0] v);
      int n;
      int hi;
      int wr0;
      int rd0;
      logic [16:0] got;
      wr0 = wr_cnt;
      rd0 = rd_cnt;
      rd_data <= v;
      mdl_u.frame(8, {16'h0, a, 1'b1}, 1'b0);
      mdl_u.handover();
      wait_lvl(1'b1, n);
      n = n + P / 2;
      chk_bit(n >= 125 && n <= 625, 1'b1);
      for (int k = 16; k >= 0; k--) begin
         wait_lvl(1'b0, hi);
         got[k] = (2 * hi > P);
         if (k > 0) wait_lvl(1'b1, n);
      end
      if (tko) mdl_u.take_low();
      n = 0;
      while (dut_oe !== 1'b0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk_bit(n >= P / 2 - 2 && n <= P / 2 + 4, 1'b1);
      if (tko) mdl_u.close_read();
      chk_word(got, {v, 1'b0});
      chk_word(17'(rd_cnt), 17'(rd0 + 1));
      chk_word(17'(rd_a), 17'(a));
      tick(10);
      wr_frame(7'h01, 16'h00ff);
      chk_word(17'(wr_cnt), 17'(wr0 + 1));
      chk_bit(cmd, 1'b1);
      $display("t_read done");
   endtask

   task automatic t_late;
      do_reset();
      tick(5100);
      chk_bit(nrun, 1'b1);
      wr_frame(EA, EK);
      chk_bit(cmd, 1'b0);
      diag <= 1'b1;
      wr_frame(EA, EK);
      chk_bit(cmd, 1'b1);
      $display("t_late done");
   endtask

   initial begin
      rst_b = 1'b0;
      n_out = 1'b1;
      diag = 1'b0;
      rd_data = 16'h0;
      bad_count = 0;
      n_checks = 0;
      wr_cnt = 0;
      rd_cnt = 0;
      t_reset();
      t_entry();
      t_write();
      t_timeout();
      t_read(1'b0, 7'h33, 16'hc35a);
      t_read(1'b1, 7'h4c, 16'h8001);
      t_late();
      give_verdict();
   end
endmodule // one_wire_programming_slave_test
